/* smbus_dac_consts.svh */
/*
  Constants shared by both ends of the two-wire DAC serial port: the
  slave address, command codes, field positions, reset values and the
  serial clock timing. Assumes a 125 MHz system clock on both ends.
*/
`ifndef SMBUS_DAC_CONSTS_SVH
`define SMBUS_DAC_CONSTS_SVH

// Fixed 7-bit slave address, binary 1001000
`define SLAVE_ADDR 7'h48
`define CMD_DATA 8'h00
`define CMD_CONFIG 8'h01
`define CFG_STANDBY_BIT 0
`define DAC_WIDTH 12
`define DAC_RESET 12'h000
`define STANDBY_RESET 1'b0

// Serial clock quarter phase: least low time, rounded up to whole cycles
`define CLK_FREQ_MHZ 125
`define SCL_T_LOW_NS 4700
`define SCL_QUARTER_CYC ((`SCL_T_LOW_NS * `CLK_FREQ_MHZ + 999) / 1000)

`endif

/* smbus_dac_pkg.sv */
/*
  Types for the two-wire DAC serial port: state enums and the packed
  state records of both ends. Assumes smbus_dac_consts.svh is included.
*/
package smbus_dac_pkg;

  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_ADDR = 4'h1,
    D_ADDR_ACK = 4'h2,
    D_CMD = 4'h3,
    D_CMD_ACK = 4'h4,
    D_WDATA = 4'h5,
    D_WDATA_ACK = 4'h6,
    D_TX = 4'h7,
    D_TX_ACK = 4'h8,
    D_IGNORE = 4'h9
  } dev_state_e;

  typedef enum logic [1:0] {
    TK_START = 2'h0,
    TK_TX = 2'h1,
    TK_RX = 2'h2,
    TK_STOP = 2'h3
  } tok_kind_e;

  typedef enum logic [2:0] {
    X_WRITE1 = 3'h0,
    X_WRITE2 = 3'h1,
    X_READ1 = 3'h2,
    X_READ2 = 3'h3,
    X_RECV1 = 3'h4,
    X_RECV2 = 3'h5
  } xfer_e;

  typedef struct packed {
    tok_kind_e kind;
    logic ack;
    logic [7:0] data;
  } token_s;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    dev_state_e state;
    logic [3:0] bitc;
    logic [7:0] shift;
    logic [7:0] txb;
    logic rw;
    logic ptr;
    logic wr_ok;
    logic mack;
    logic [1:0] byte_idx;
    logic sda_low;
    logic [11:0] dac;
    logic standby;
    logic conv_en;
  } dev_state_s;

  typedef struct packed {
    logic sda_s1;
    logic sda_s2;
    logic busy;
    logic done;
    logic nack;
    token_s [7:0] tok;
    logic [2:0] tidx;
    logic [2:0] last;
    logic [3:0] bitn;
    logic [1:0] q;
    logic [9:0] cnt;
    logic scl_low;
    logic sda_low;
    logic [15:0] rdata;
  } mst_state_s;

endpackage

/* smbus_if.sv */
/*
  Two-wire bus between the DAC slave port and its master. Both lines
  are open drain with a pull-up: a party pulls low while its enable is
  high. Assumes nothing else drives the bus.
*/
interface smbus_if;
  logic scl_mst_out;
  logic scl_mst_oe;
  logic sda_mst_out;
  logic sda_mst_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  assign scl = ~(scl_mst_oe & ~scl_mst_out);
  assign sda = ~((sda_mst_oe & ~sda_mst_out) | (sda_dev_oe & ~sda_dev_out));

  modport device (
    input scl,
    input sda,
    output sda_dev_out,
    output sda_dev_oe
  );

  modport master (
    input sda,
    output scl_mst_out,
    output scl_mst_oe,
    output sda_mst_out,
    output sda_mst_oe
  );
endinterface

/* smbus_dac_master.sv */
/*
  Bus master end: on a request it plays a list of start, byte and stop
  units on the bus, making the serial clock from clk_in by a divider.
  Assumes the slave never stretches the clock.
*/
`include "smbus_dac_consts.svh"

module smbus_dac_master
  import smbus_dac_pkg::*;
#(
  parameter int QUARTER_CYC = `SCL_QUARTER_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  smbus_if.master bus,
  input wire logic start_in,
  input wire xfer_e xfer_in,
  input wire logic [7:0] cmd_in,
  input wire logic [7:0] wdata0_in,
  input wire logic [7:0] wdata1_in,
  output logic busy_out,
  output logic done_out,
  output logic nack_out,
  output logic [15:0] rdata_out
);

  mst_state_s st;
  mst_state_s next_st;

  function automatic token_s mk(input tok_kind_e k, input logic a,
                                input logic [7:0] d);
    token_s t;
    t.kind = k;
    t.ack = a;
    t.data = d;
    return t;
  endfunction

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    token_s tk;
    logic [2:0] k;
    logic two;
    tk = st.tok[st.tidx];
    k = 3'h0;
    two = (xfer_in == X_WRITE2) || (xfer_in == X_READ2) ||
          (xfer_in == X_RECV2);
    next_st = st;
    next_st.sda_s1 = bus.sda;
    next_st.sda_s2 = st.sda_s1;
    next_st.done = 1'b0;
    if (!st.busy) begin
      if (start_in) begin
        next_st.tok = '0;
        next_st.tok[k] = mk(TK_START, 1'b0, 8'h00);
        k = k + 3'h1;
        if (xfer_in != X_RECV1 && xfer_in != X_RECV2) begin
          // First phase always writes the command byte
          next_st.tok[k] = mk(TK_TX, 1'b0, {`SLAVE_ADDR, 1'b0});
          k = k + 3'h1;
          next_st.tok[k] = mk(TK_TX, 1'b0, cmd_in);
          k = k + 3'h1;
        end
        if (xfer_in == X_WRITE1 || xfer_in == X_WRITE2) begin
          next_st.tok[k] = mk(TK_TX, 1'b0, wdata0_in);
          k = k + 3'h1;
          if (two) begin
            next_st.tok[k] = mk(TK_TX, 1'b0, wdata1_in);
            k = k + 3'h1;
          end
        end else begin
          if (xfer_in == X_READ1 || xfer_in == X_READ2) begin
            next_st.tok[k] = mk(TK_START, 1'b0, 8'h00);
            k = k + 3'h1;
          end
          next_st.tok[k] = mk(TK_TX, 1'b0, {`SLAVE_ADDR, 1'b1});
          k = k + 3'h1;
          if (two) begin
            next_st.tok[k] = mk(TK_RX, 1'b1, 8'h00);
            k = k + 3'h1;
          end
          next_st.tok[k] = mk(TK_RX, 1'b0, 8'h00);
          k = k + 3'h1;
        end
        next_st.tok[k] = mk(TK_STOP, 1'b0, 8'h00);
        next_st.last = k;
        next_st.tidx = 3'h0;
        next_st.busy = 1'b1;
        next_st.nack = 1'b0;
        next_st.rdata = 16'h0000;
        next_st.bitn = 4'h0;
        next_st.q = 2'h0;
        next_st.cnt = 10'h000;
      end
    end else if (st.cnt != 10'(QUARTER_CYC - 1)) begin
      next_st.cnt = st.cnt + 10'h001;
    end else begin
      next_st.cnt = 10'h000;
      next_st.q = st.q + 2'h1;
      case (st.q)
        2'h0: begin
          // Data moves only a quarter after the clock fell
          if (tk.kind == TK_START) begin
            next_st.sda_low = 1'b0;
          end else if (tk.kind == TK_STOP) begin
            next_st.sda_low = 1'b1;
          end else if (tk.kind == TK_TX) begin
            next_st.sda_low = (st.bitn != 4'h8) &&
                              !tk.data[3'h7 - st.bitn[2:0]];
          end else begin
            next_st.sda_low = (st.bitn == 4'h8) && tk.ack;
          end
        end
        2'h1: begin
          next_st.scl_low = 1'b0;
        end
        2'h2: begin
          if (tk.kind == TK_START) begin
            next_st.sda_low = 1'b1;
          end else if (tk.kind == TK_STOP) begin
            next_st.sda_low = 1'b0;
          end else if (tk.kind == TK_TX && st.bitn == 4'h8) begin
            next_st.nack = st.nack | st.sda_s2;
          end else if (tk.kind == TK_RX && st.bitn != 4'h8) begin
            next_st.rdata = {st.rdata[14:0], st.sda_s2};
          end
        end
        default: begin
          if (tk.kind == TK_STOP) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
          end else begin
            next_st.scl_low = 1'b1;
            if (tk.kind == TK_START) begin
              next_st.tidx = st.tidx + 3'h1;
            end else if (st.bitn == 4'h8) begin
              next_st.bitn = 4'h0;
              // A refused byte ends the transfer with a stop
              next_st.tidx = st.nack ? st.last : st.tidx + 3'h1;
            end else begin
              next_st.bitn = st.bitn + 4'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.scl_mst_out = 1'b0;
  assign bus.scl_mst_oe = st.scl_low;
  assign bus.sda_mst_out = 1'b0;
  assign bus.sda_mst_oe = st.sda_low;
  assign busy_out = st.busy;
  assign done_out = st.done;
  assign nack_out = st.nack;
  assign rdata_out = st.rdata;

endmodule

/* smbus_dac_slave.sv */
/*
  Slave end of the two-wire DAC serial port: start/stop detection,
  address match, command decode, data and configuration registers,
  one- or two-byte writes and reads. Assumes the master makes every
  clock pulse and that scl and sda are asynchronous to clk_in.
*/
`include "smbus_dac_consts.svh"

module smbus_dac_slave
  import smbus_dac_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  smbus_if.device bus,
  output logic [`DAC_WIDTH-1:0] dac_value_out,
  output logic standby_out,
  output logic convert_en_out
);

  dev_state_s st;
  dev_state_s next_st;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  // Byte returned for a read, by register and position in the transfer
  function automatic logic [7:0] rd_byte(input logic ptr,
                                         input logic [1:0] idx,
                                         input logic [11:0] dac,
                                         input logic sb);
    logic [7:0] b;
    b = 8'h00;
    if (!ptr && idx == 2'h0) begin
      b = dac[11:4];
    end else if (!ptr && idx == 2'h1) begin
      b = {dac[3:0], 4'h0};
    end else if (ptr && idx == 2'h0) begin
      b[`CFG_STANDBY_BIT] = sb;
    end
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Edge and condition detection on the synchronised lines. Only the
  // second and third stages are looked at, so a metastable first stage
  // never reaches the decoder.
  assign rise = st.scl_s2 & ~st.scl_s3;
  assign fall = ~st.scl_s2 & st.scl_s3;
  assign start_c = st.scl_s2 & st.scl_s3 & st.sda_s3 & ~st.sda_s2;
  assign stop_c = st.scl_s2 & st.scl_s3 & ~st.sda_s3 & st.sda_s2;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.scl_s1 = bus.scl;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_s3 = st.scl_s2;
    next_st.sda_s1 = bus.sda;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_s3 = st.sda_s2;
    if (start_c) begin
      // A repeated start also lands here and restarts address capture
      next_st.state = D_ADDR;
      next_st.bitc = 4'h0;
      next_st.sda_low = 1'b0;
    end else if (stop_c) begin
      next_st.state = D_IDLE;
      next_st.sda_low = 1'b0;
    end else begin
      case (st.state)
        D_ADDR, D_CMD, D_WDATA: begin
          if (rise && st.bitc != 4'h8) begin
            // Sampled on the rising edge, where data is stable
            next_st.shift = {st.shift[6:0], st.sda_s2};
            next_st.bitc = st.bitc + 4'h1;
          end else if (fall && st.bitc == 4'h8) begin
            next_st.bitc = 4'h0;
            if (st.state == D_ADDR) begin
              if (st.shift[7:1] == `SLAVE_ADDR) begin
                next_st.rw = st.shift[0];
                next_st.sda_low = 1'b1;
                next_st.state = D_ADDR_ACK;
              end else begin
                next_st.state = D_IGNORE;
              end
            end else if (st.state == D_CMD) begin
              // Command byte is always acknowledged; a bad code only
              // disarms the data phase and leaves the pointer alone
              if (st.shift == `CMD_DATA || st.shift == `CMD_CONFIG) begin
                next_st.ptr = st.shift[0];
                next_st.wr_ok = 1'b1;
              end else begin
                next_st.wr_ok = 1'b0;
              end
              next_st.sda_low = 1'b1;
              next_st.byte_idx = 2'h0;
              next_st.state = D_CMD_ACK;
            end else if (st.wr_ok && st.byte_idx != 2'h2) begin
              if (!st.ptr && st.byte_idx == 2'h0) begin
                next_st.dac[11:4] = st.shift;
              end else if (!st.ptr) begin
                next_st.dac[3:0] = st.shift[7:4];
              end else if (st.byte_idx == 2'h0) begin
                next_st.standby = st.shift[`CFG_STANDBY_BIT];
              end
              next_st.byte_idx = st.byte_idx + 2'h1;
              next_st.sda_low = 1'b1;
              next_st.state = D_WDATA_ACK;
            end else begin
              // Unknown command or a third byte: not taken, not acked
              next_st.state = D_IGNORE;
            end
          end
        end
        D_ADDR_ACK: begin
          if (fall) begin
            next_st.bitc = 4'h0;
            next_st.byte_idx = 2'h0;
            if (st.rw) begin
              // Pointer kept from the last command selects the source
              next_st.txb = rd_byte(st.ptr, 2'h0, st.dac,
                                    st.standby);
              next_st.sda_low = ~next_st.txb[7];
              next_st.state = D_TX;
            end else begin
              next_st.sda_low = 1'b0;
              next_st.state = D_CMD;
            end
          end
        end
        D_CMD_ACK, D_WDATA_ACK: begin
          if (fall) begin
            next_st.sda_low = 1'b0;
            next_st.state = D_WDATA;
          end
        end
        D_TX: begin
          if (fall) begin
            if (st.bitc == 4'h7) begin
              next_st.bitc = 4'h0;
              next_st.sda_low = 1'b0;
              next_st.state = D_TX_ACK;
            end else begin
              next_st.txb = {st.txb[6:0], 1'b0};
              next_st.sda_low = ~st.txb[6];
              next_st.bitc = st.bitc + 4'h1;
            end
          end
        end
        D_TX_ACK: begin
          if (rise) begin
            next_st.mack = ~st.sda_s2;
          end else if (fall) begin
            if (st.mack) begin
              next_st.byte_idx = (st.byte_idx == 2'h2) ? 2'h2 :
                                 st.byte_idx + 2'h1;
              next_st.txb = rd_byte(st.ptr, next_st.byte_idx, st.dac,
                                    st.standby);
              next_st.sda_low = ~next_st.txb[7];
              next_st.state = D_TX;
            end else begin
              // No-acknowledge: let go of the line and wait for stop
              next_st.state = D_IGNORE;
            end
          end
        end
        default: begin
          // Idle or ignoring the bus until the next start or stop: line stays released
          next_st.sda_low = 1'b0;
        end
      endcase
    end
    next_st.conv_en = ~next_st.standby;
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '0;
      st.scl_s1 <= 1'b1;
      st.scl_s2 <= 1'b1;
      st.scl_s3 <= 1'b1;
      st.sda_s1 <= 1'b1;
      st.sda_s2 <= 1'b1;
      st.sda_s3 <= 1'b1;
      st.state <= D_IDLE;
      st.dac <= `DAC_RESET;
      st.standby <= `STANDBY_RESET;
      st.conv_en <= ~`STANDBY_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Open drain: the pin is only ever pulled low, never driven high
  assign bus.sda_dev_out = 1'b0;
  assign bus.sda_dev_oe = st.sda_low;
  assign dac_value_out = st.dac;
  assign standby_out = st.standby;
  assign convert_en_out = st.conv_en;

endmodule

/* smbus_dac_props.sv */
/*
  Checker for the two-wire bus joining the master and slave ends.
  Assumes the bus signals arrive as plain inputs, all sampled on clk_in.
*/
`include "smbus_dac_consts.svh"

module smbus_dac_props (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic scl_mst_out,
  input wire logic scl_mst_oe,
  input wire logic sda_mst_out,
  input wire logic sda_mst_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  logic scl_q;
  logic sda_q;
  logic seen;
  logic rw;
  logic aok;
  logic [3:0] cnt;
  logic [2:0] nbyte;
  logic [7:0] sh;
  wire logic rise;
  wire logic start_ev;
  wire logic stop_ev;

  assign rise = scl & ~scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;

  // Bit and byte position since the latest start; cnt 8 marks the ninth
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      seen <= 1'b0;
      rw <= 1'b0;
      aok <= 1'b0;
      cnt <= 4'h0;
      nbyte <= 3'h0;
      sh <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev) begin
        seen <= 1'b1;
        cnt <= 4'h0;
        nbyte <= 3'h0;
      end else if (rise && cnt == 4'h8) begin
        cnt <= 4'h0;
        nbyte <= (nbyte == 3'h7) ? nbyte : nbyte + 3'h1;
        if (nbyte == 3'h0) begin
          rw <= sh[0];
          aok <= (sh[7:1] == `SLAVE_ADDR);
        end
      end else if (rise) begin
        cnt <= cnt + 4'h1;
        sh <= {sh[6:0], sda};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  property p_quiet_before_start;
    !seen |-> !sda_dev_oe;
  endproperty
  a_quiet_before_start: assert property (p_quiet_before_start)
    else $error("slave drove sda before any start");

  property p_dev_change_low;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  a_dev_change_low: assert property (p_dev_change_low)
    else $error("slave changed sda while scl high");

  property p_addr_ack;
    rise && cnt == 4'h8 && nbyte == 3'h0 |->
      sda_dev_oe == (sh[7:1] == `SLAVE_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge does not match address");

  property p_dev_silent_write;
    rise && cnt != 4'h8 && (nbyte == 3'h0 || !rw) |-> !sda_dev_oe;
  endproperty
  a_dev_silent_write: assert property (p_dev_silent_write)
    else $error("slave drove a bit of a master byte");

  property p_mst_release_ack;
    rise && cnt == 4'h8 && (nbyte == 3'h0 || !rw) |-> !sda_mst_oe;
  endproperty
  a_mst_release_ack: assert property (p_mst_release_ack)
    else $error("master held sda on ninth pulse of its byte");

  property p_cmd_ack;
    rise && cnt == 4'h8 && nbyte == 3'h1 && !rw && aok |-> sda_dev_oe;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack)
    else $error("command byte not acknowledged");

  // Bits 2 to 8 only: the rise inside a stop follows a ninth pulse
  property p_mst_release_read;
    rise && cnt != 4'h0 && cnt != 4'h8 && nbyte != 3'h0 && rw
      |-> !sda_mst_oe;
  endproperty
  a_mst_release_read: assert property (p_mst_release_read)
    else $error("master drove sda during a read bit");

  property p_idle_released;
    stop_ev |=> !sda_dev_oe [*8];
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("slave drove sda after stop");
endmodule

/* dac_smbus_slave_port_test.sv */
/*
  Bench: master and slave ends on one bus, checked against a register
  model; a second slave on a bench-driven bus takes malformed traffic.
  Assumes the shared constants header and package.
*/
`include "smbus_dac_consts.svh"

module dac_smbus_slave_port_test
  import smbus_dac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in;
  logic srst_in;
  logic start_in;
  xfer_e xfer_in;
  logic [7:0] cmd_in;
  logic [7:0] wdata0_in;
  logic [7:0] wdata1_in;
  logic busy_out;
  logic done_out;
  logic nack_out;
  logic [15:0] rdata_out;
  logic [11:0] dac_value_out;
  logic [11:0] dac_b;
  logic standby_out;
  logic convert_en_out;
  logic standby_b;
  logic convert_en_b;
  logic ack;
  int n_fail = 0;
  int checked = 0;
  int seed = 79;
  int m_dac;
  int m_sb;
  int m_ptr;
  logic [7:0] cmd_tab [3] = '{8'h00, 8'h01, 8'h5a};

  smbus_if bus_a();
  smbus_if bus_b();

  initial clk_in = 1'b0;
  always #4 clk_in = ~clk_in;

  smbus_dac_master #(.QUARTER_CYC(8)) u_smbus_dac_master (
    .clk_in(clk_in), .srst_in(srst_in), .bus(bus_a),
    .start_in(start_in), .xfer_in(xfer_in), .cmd_in(cmd_in),
    .wdata0_in(wdata0_in), .wdata1_in(wdata1_in), .busy_out(busy_out),
    .done_out(done_out), .nack_out(nack_out), .rdata_out(rdata_out));
  smbus_dac_slave u_smbus_dac_slave (.clk_in(clk_in), .srst_in(srst_in),
    .bus(bus_a), .dac_value_out(dac_value_out), .standby_out(standby_out),
    .convert_en_out(convert_en_out));
  smbus_dac_slave u_smbus_dac_slave_b (.clk_in(clk_in), .srst_in(srst_in),
    .bus(bus_b), .dac_value_out(dac_b), .standby_out(standby_b),
    .convert_en_out(convert_en_b));
  smbus_dac_props u_smbus_dac_props (.clk_in(clk_in), .srst_in(srst_in),
    .scl_mst_out(bus_a.scl_mst_out), .scl_mst_oe(bus_a.scl_mst_oe),
    .sda_mst_out(bus_a.sda_mst_out), .sda_mst_oe(bus_a.sda_mst_oe),
    .sda_dev_out(bus_a.sda_dev_out), .sda_dev_oe(bus_a.sda_dev_oe),
    .scl(bus_a.scl), .sda(bus_a.sda));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One transfer through the master end, predicted by the model first
  task automatic run(input int x, input int c, input int d0, input int d1);
    int rd;
    int nk;
    int b0;
    int b1;
    int known;
    known = (c == 0 || c == 1);
    rd = 0;
    nk = 0;
    if (x <= 3 && known) m_ptr = c;
    if (x <= 1) begin
      if (!known) nk = 1;
      else if (c == 1) m_sb = d0 & 1;
      else if (x == 1) m_dac = (d0 << 4) | (d1 >> 4);
      else m_dac = (d0 << 4) | (m_dac & 15);
    end else begin
      b0 = m_ptr ? m_sb : m_dac >> 4;
      b1 = m_ptr ? 0 : (m_dac & 15) << 4;
      rd = (x % 2 == 1) ? (b0 << 8) | b1 : b0;
    end
    start_in = 1'b1;
    xfer_in = xfer_e'(x);
    cmd_in = c[7:0];
    wdata0_in = d0[7:0];
    wdata1_in = d1[7:0];
    @(negedge clk_in);
    start_in = 1'b0;
    chk(busy_out, 1'b1);
    for (int i = 0; i < 2000 && done_out !== 1'b1; i++) @(negedge clk_in);
    if (done_out !== 1'b1) begin
      n_fail++;
      test_done();
    end
    chk(rdata_out, rd[15:0]);
    chk(nack_out, nk[0]);
    chk(dac_value_out, m_dac[11:0]);
    chk(standby_out, m_sb[0]);
    chk(convert_en_out, !m_sb[0]);
  endtask

  // Bench-made link clock: four quarters of five cycles, 160 ns a bit
  task automatic bq(input logic c, input logic d);
    bus_b.scl_mst_oe = ~c;
    bus_b.sda_mst_oe = ~d;
    repeat (5) @(negedge clk_in);
  endtask

  task automatic bbyte(input logic [7:0] v, output logic a);
    logic b;
    for (int i = 7; i >= -1; i--) begin
      b = (i >= 0) ? v[i[2:0]] : 1'b1;
      bq(1'b0, b);
      bq(1'b1, b);
      a = ~bus_b.sda;
      bq(1'b1, b);
      bq(1'b0, b);
    end
  endtask

  task automatic bstart();
    bq(1'b1, 1'b1);
    bq(1'b1, 1'b0);
    bq(1'b0, 1'b0);
  endtask

  task automatic bstop();
    bq(1'b0, 1'b0);
    bq(1'b1, 1'b0);
    bq(1'b1, 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    srst_in = 1'b1;
    start_in = 1'b0;
    xfer_in = X_WRITE1;
    cmd_in = 8'h00;
    wdata0_in = 8'h00;
    wdata1_in = 8'h00;
    bus_b.scl_mst_out = 1'b0;
    bus_b.sda_mst_out = 1'b0;
    bus_b.scl_mst_oe = 1'b0;
    bus_b.sda_mst_oe = 1'b0;
    m_dac = 0;
    m_sb = 0;
    m_ptr = 0;
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk(dac_value_out, `DAC_RESET);
    chk(standby_out, `STANDBY_RESET);
    chk(convert_en_out, 1'b1);
    // Clocked byte with no start, then a foreign address
    bbyte({`SLAVE_ADDR, 1'b0}, ack);
    chk(ack, 1'b0);
    bstart();
    bbyte({`SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
    chk(ack, 1'b0);
    bbyte(`CMD_DATA, ack);
    chk(ack, 1'b0);
    bbyte(8'hab, ack);
    chk(ack, 1'b0);
    bstop();
    bstart();
    bbyte({`SLAVE_ADDR, 1'b0}, ack);
    chk(ack, 1'b1);
    bbyte(`CMD_DATA, ack);
    chk(ack, 1'b1);
    bbyte(8'hc3, ack);
    chk(ack, 1'b1);
    bbyte(8'h5f, ack);
    chk(ack, 1'b1);
    bbyte(8'h77, ack);
    chk(ack, 1'b0);
    bstop();
    bbyte({`SLAVE_ADDR, 1'b0}, ack);
    chk(ack, 1'b0);
    chk(dac_b, 12'hc35);
    chk(standby_b, 1'b0);
    // Every transfer kind under each command code, then random traffic
    for (int c = 0; c < 3; c++) begin
      for (int x = 0; x < 6; x++) begin
        run(x, cmd_tab[c], $random(seed) & 255, $random(seed) & 255);
      end
    end
    for (int i = 0; i < 30; i++) begin
      run({$random(seed)} % 6, cmd_tab[{$random(seed)} % 3],
          $random(seed) & 255, $random(seed) & 255);
    end
    test_done();
  end

  // Whole run needs about 53k cycles; 80k cycles means a hang
  initial begin
    #(80000 * 8);
    n_fail++;
    test_done();
  end
endmodule
